/* pkg/spfm_defines.svh */
// constants of the four-mode serial port: sfr addresses, bit positions,
// reset values and divider counts; assumes inclusion by bare name
`ifndef SPFM_DEFINES_SVH
`define SPFM_DEFINES_SVH

// sfr addresses on the cpu special function bus
`define SPFM_ADDR_CTRL 8'h98
`define SPFM_ADDR_DATA 8'h99
`define SPFM_ADDR_RELL 8'hAA
`define SPFM_ADDR_RELH 8'hBA
`define SPFM_ADDR_INTERRUPT_ENABLE_ZERO 8'hA8
`define SPFM_ADDR_PCON 8'h87

// serial_control bit positions
`define SPFM_CTL_MODE_HI 7
`define SPFM_CTL_MODE_LO 6
`define SPFM_CTL_MPE 5
`define SPFM_CTL_REN 4
`define SPFM_CTL_TB8 3
`define SPFM_CTL_RB8 2
`define SPFM_CTL_TI 1
`define SPFM_CTL_RI 0

// bits of the shared interrupt enable and power control registers
`define SPFM_IEN_EAL 7
`define SPFM_IEN_ES 4
`define SPFM_PCON_SMOD 7

// reset values
`define SPFM_RST_BYTE 8'h00
`define SPFM_RST_TXSHIFT 11'h7FF

// mode select codes
`define SPFM_MODE0 2'h0
`define SPFM_MODE1 2'h1
`define SPFM_MODE2 2'h2

// dividers: mode 0 period, oversampling, baud prescale
`define SPFM_M0_LAST 4'hB
`define SPFM_M0_HALF 4'h6
`define SPFM_OVS_LAST 4'hF
`define SPFM_OVS_MID 4'h7
`define SPFM_PRE_NORM 2'h3
`define SPFM_PRE_DBL 2'h1
`define SPFM_REL_MAX 10'h3FF

// frame lengths in bits
`define SPFM_BITS_M0 4'h8
`define SPFM_BITS_M1 4'hA
`define SPFM_BITS_M23 4'hB
`define SPFM_RXBITS_M1 4'h9
`define SPFM_RXBITS_M23 4'hA

`endif

/* pkg/spfm_pkg.sv */
// types of the four-mode serial port
// assumes the defines header is compiled alongside
package spfm_pkg;

   typedef enum logic {
      SPFM_TX_IDLE,
      SPFM_TX_SHIFT
   } spfm_tx_state_t;

   typedef enum logic [1:0] {
      SPFM_RX_IDLE,
      SPFM_RX_START,
      SPFM_RX_DATA,
      SPFM_RX_SHIFT0
   } spfm_rx_state_t;

endpackage

/* hdl/spfm_pair_fifo.sv */
// small flip-flop fifo with valid/ready on both sides
// assumes one clock and an asynchronous active high reset
`timescale 1ns/1ns
module spfm_pair_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 2
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   // occupancy needs one bit more than the pointers to tell full apart
   localparam logic [AW:0] FULL_COUNT = DEPTH[AW:0];

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wrPtr_reg;
   logic [AW-1:0] rdPtr_reg;
   logic [AW:0] count_reg;
   logic doPush;
   logic doPop;

   // honest full and empty straight from the occupancy count
   assign inReady = (count_reg != FULL_COUNT);
   assign outValid = (count_reg != '0);
   assign outData = mem_reg[rdPtr_reg];
   assign doPush = inValid && inReady;
   assign doPop = outValid && outReady;

   ////////////////////////////////////////////////////////////////////
   // storage, written only at the write pointer
   always_ff @(posedge clk_sys) begin
      if (doPush) begin
         mem_reg[wrPtr_reg] <= inData;
      end
   end

   // pointers wrap at the depth
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (doPush) begin
            wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0
                         : wrPtr_reg + 1'b1;
         end
         if (doPop) begin
            rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0
                         : rdPtr_reg + 1'b1;
         end
         count_reg <= count_reg + {{AW{1'b0}}, doPush}
                      - {{AW{1'b0}}, doPop};
      end
   end
endmodule

/* hdl/spfm_serial_port.sv */
// four-mode serial port: shift register mode and three uart modes
// assumes cpu sfr strobes and pins synchronous to clk_sys
`timescale 1ns/1ns
`include "spfm_defines.svh"
module spfm_serial_port #(
   parameter int RX_DEPTH = 2
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWrEn,
   input wire logic sfrRdEn,
   input wire logic [7:0] sfrWrData,
   output logic [7:0] sfrRdData,
   input wire logic serialInPinIn,
   output logic serialInPinOut,
   output logic serialInPinOe,
   output logic serialOutPin,
   output logic serialIrq
);
   logic [7:0] ctrl_reg;
   logic [7:0] rxData_reg;
   logic [7:0] relLow_reg;
   logic [7:0] relHigh_reg;
   logic [7:0] ien_reg;
   logic [7:0] pcon_reg;
   logic [7:0] sfrRdData_next;
   logic txDone_reg;
   logic rxDone_reg;
   logic rxNinth_reg;
   logic [1:0] mode;
   logic smod;
   logic [9:0] reload;
   logic wrCtrl;
   logic txStart;
   logic [9:0] baudCnt_reg;
   logic [1:0] preCnt_reg;
   logic baudOvf;
   logic tick16;
   logic [3:0] m0Cnt_reg;
   logic m0Step;
   spfm_pkg::spfm_tx_state_t txState_reg;
   logic [10:0] txShift_reg;
   logic [3:0] txLeft_reg;
   logic [3:0] txTick_reg;
   logic txStep;
   logic txEnd;
   spfm_pkg::spfm_rx_state_t rxState_reg;
   logic [9:0] rxShift_reg;
   logic [3:0] rxBits_reg;
   logic [3:0] rxTick_reg;
   logic rxPrev_reg;
   logic rxM0Start;
   logic rxUartStart;
   logic rxFinish;
   logic rxAccept;
   logic [9:0] rxWord;
   logic fifoInReady;
   logic fifoOutValid;
   logic [9:0] fifoOutData;
   logic rxPop;
   logic serialOutPin_next;

   assign mode = {ctrl_reg[`SPFM_CTL_MODE_HI], ctrl_reg[`SPFM_CTL_MODE_LO]};
   assign smod = pcon_reg[`SPFM_PCON_SMOD];
   assign reload = {relHigh_reg[1:0], relLow_reg};
   assign wrCtrl = sfrWrEn && (sfrAddr == `SPFM_ADDR_CTRL);
   assign txStart = sfrWrEn && (sfrAddr == `SPFM_ADDR_DATA);

   ////////////////////////////////////////////////////////////////////
   // plain configuration registers, all writable by the cpu
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_reg <= `SPFM_RST_BYTE;
         relLow_reg <= `SPFM_RST_BYTE;
         relHigh_reg <= `SPFM_RST_BYTE;
         ien_reg <= `SPFM_RST_BYTE;
         pcon_reg <= `SPFM_RST_BYTE;
      end else if (sfrWrEn) begin
         unique case (sfrAddr)
            `SPFM_ADDR_CTRL: ctrl_reg <= sfrWrData;
            `SPFM_ADDR_RELL: relLow_reg <= sfrWrData;
            `SPFM_ADDR_RELH: relHigh_reg <= sfrWrData;
            `SPFM_ADDR_INTERRUPT_ENABLE_ZERO: ien_reg <= sfrWrData;
            `SPFM_ADDR_PCON: pcon_reg <= sfrWrData;
            default: ;
         endcase
      end
   end

   // sticky flags: a hardware set wins over a cpu write in the same cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         txDone_reg <= 1'b0;
         rxDone_reg <= 1'b0;
         rxNinth_reg <= 1'b0;
      end else begin
         if (txEnd) begin
            txDone_reg <= 1'b1;
         end else if (wrCtrl) begin
            txDone_reg <= sfrWrData[`SPFM_CTL_TI];
         end
         if (rxPop) begin
            rxDone_reg <= 1'b1;
         end else if (wrCtrl) begin
            rxDone_reg <= sfrWrData[`SPFM_CTL_RI];
         end
         if (rxPop && fifoOutData[9]) begin
            rxNinth_reg <= fifoOutData[8];
         end else if (wrCtrl) begin
            rxNinth_reg <= sfrWrData[`SPFM_CTL_RB8];
         end
      end
   end

   // read data is registered: it shows one edge after the read strobe
   always_comb begin
      sfrRdData_next = `SPFM_RST_BYTE;
      unique case (sfrAddr)
         `SPFM_ADDR_CTRL: begin
            sfrRdData_next = ctrl_reg;
            sfrRdData_next[`SPFM_CTL_RB8] = rxNinth_reg;
            sfrRdData_next[`SPFM_CTL_TI] = txDone_reg;
            sfrRdData_next[`SPFM_CTL_RI] = rxDone_reg;
         end
         `SPFM_ADDR_DATA: sfrRdData_next = rxData_reg;
         `SPFM_ADDR_RELL: sfrRdData_next = relLow_reg;
         `SPFM_ADDR_RELH: sfrRdData_next = relHigh_reg;
         `SPFM_ADDR_INTERRUPT_ENABLE_ZERO: sfrRdData_next = ien_reg;
         `SPFM_ADDR_PCON: sfrRdData_next = pcon_reg;
         default: sfrRdData_next = `SPFM_RST_BYTE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sfrRdData <= `SPFM_RST_BYTE;
      end else if (sfrRdEn) begin
         sfrRdData <= sfrRdData_next;
      end
   end

   // request gated by both enables; level while a flag stands
   assign serialIrq = ien_reg[`SPFM_IEN_EAL] && ien_reg[`SPFM_IEN_ES]
                      && (txDone_reg || rxDone_reg);

   ////////////////////////////////////////////////////////////////////
   // reload generator: overflows every 1024-reload clocks, or every
   // clock in mode 2 so the prescaler alone gives the fixed rate
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         baudCnt_reg <= '0;
      end else if (baudCnt_reg == `SPFM_REL_MAX) begin
         baudCnt_reg <= reload;
      end else begin
         baudCnt_reg <= baudCnt_reg + 1'b1;
      end
   end

   assign baudOvf = (mode == `SPFM_MODE2) ? 1'b1
                    : (baudCnt_reg == `SPFM_REL_MAX);

   // prescale by 4, or by 2 when baud double is set; 16 ticks per bit
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         preCnt_reg <= '0;
      end else if (baudOvf) begin
         preCnt_reg <= tick16 ? 2'h0 : preCnt_reg + 1'b1;
      end
   end

   assign tick16 = baudOvf && (preCnt_reg ==
                   (smod ? `SPFM_PRE_DBL : `SPFM_PRE_NORM));

   // mode 0 period of twelve clocks, restarted by each transfer
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         m0Cnt_reg <= '0;
      end else if (txStart || rxM0Start || m0Step) begin
         m0Cnt_reg <= '0;
      end else begin
         m0Cnt_reg <= m0Cnt_reg + 1'b1;
      end
   end

   assign m0Step = (m0Cnt_reg == `SPFM_M0_LAST);

   ////////////////////////////////////////////////////////////////////
   // transmitter; a write while busy restarts with the new byte
   assign txStep = (mode == `SPFM_MODE0) ? m0Step
                   : (tick16 && (txTick_reg == `SPFM_OVS_LAST));
   assign txEnd = (txState_reg == spfm_pkg::SPFM_TX_SHIFT) && txStep
                  && (txLeft_reg == 4'h1) && !txStart;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         txState_reg <= spfm_pkg::SPFM_TX_IDLE;
         txShift_reg <= `SPFM_RST_TXSHIFT;
         txLeft_reg <= '0;
      end else if (txStart) begin
         txState_reg <= spfm_pkg::SPFM_TX_SHIFT;
         unique case (mode)
            `SPFM_MODE0: begin
               txShift_reg <= {3'h7, sfrWrData};
               txLeft_reg <= `SPFM_BITS_M0;
            end
            `SPFM_MODE1: begin
               txShift_reg <= {2'h3, sfrWrData, 1'b0};
               txLeft_reg <= `SPFM_BITS_M1;
            end
            default: begin
               txShift_reg <= {1'b1, ctrl_reg[`SPFM_CTL_TB8],
                               sfrWrData, 1'b0};
               txLeft_reg <= `SPFM_BITS_M23;
            end
         endcase
      end else if (txState_reg == spfm_pkg::SPFM_TX_SHIFT && txStep) begin
         txShift_reg <= {1'b1, txShift_reg[10:1]};
         txLeft_reg <= txLeft_reg - 1'b1;
         if (txLeft_reg == 4'h1) begin
            txState_reg <= spfm_pkg::SPFM_TX_IDLE;
         end
      end
   end

   // oversample phase of the current transmit bit
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         txTick_reg <= '0;
      end else if (txStart) begin
         txTick_reg <= '0;
      end else if (tick16) begin
         txTick_reg <= txTick_reg + 1'b1;
      end
   end

   // mode 0 shift clock idles high, low for the first half period
   always_comb begin
      serialOutPin_next = 1'b1;
      if (mode == `SPFM_MODE0) begin
         if (txState_reg == spfm_pkg::SPFM_TX_SHIFT
             || rxState_reg == spfm_pkg::SPFM_RX_SHIFT0) begin
            serialOutPin_next = (m0Cnt_reg >= `SPFM_M0_HALF);
         end
      end else if (txState_reg == spfm_pkg::SPFM_TX_SHIFT) begin
         serialOutPin_next = txShift_reg[0];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         serialOutPin <= 1'b1;
      end else begin
         serialOutPin <= serialOutPin_next;
      end
   end

   // mode 0 drives data on the input pin only while sending
   assign serialInPinOut = txShift_reg[0];
   assign serialInPinOe = (mode == `SPFM_MODE0)
                          && (txState_reg == spfm_pkg::SPFM_TX_SHIFT);

   ////////////////////////////////////////////////////////////////////
   // receiver; starts only with room in the buffer, so no word is lost
   assign rxM0Start = (mode == `SPFM_MODE0) && ctrl_reg[`SPFM_CTL_REN]
                      && !rxDone_reg && fifoInReady && !txStart
                      && rxState_reg == spfm_pkg::SPFM_RX_IDLE
                      && txState_reg == spfm_pkg::SPFM_TX_IDLE;
   assign rxUartStart = (mode != `SPFM_MODE0) && ctrl_reg[`SPFM_CTL_REN]
                        && fifoInReady && rxPrev_reg && !serialInPinIn
                        && rxState_reg == spfm_pkg::SPFM_RX_IDLE;
   assign rxFinish = ((rxState_reg == spfm_pkg::SPFM_RX_SHIFT0 && m0Step)
                     || (rxState_reg == spfm_pkg::SPFM_RX_DATA && tick16
                     && rxTick_reg == `SPFM_OVS_LAST))
                     && rxBits_reg == 4'h1;

   // previous pin level for start edge detection
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rxPrev_reg <= 1'b1;
      end else begin
         rxPrev_reg <= serialInPinIn;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rxState_reg <= spfm_pkg::SPFM_RX_IDLE;
         rxShift_reg <= '0;
         rxBits_reg <= '0;
         rxTick_reg <= '0;
      end else if (!ctrl_reg[`SPFM_CTL_REN]) begin
         rxState_reg <= spfm_pkg::SPFM_RX_IDLE;
      end else begin
         unique case (rxState_reg)
            spfm_pkg::SPFM_RX_IDLE: begin
               rxTick_reg <= '0;
               if (rxM0Start) begin
                  rxState_reg <= spfm_pkg::SPFM_RX_SHIFT0;
                  rxBits_reg <= `SPFM_BITS_M0;
               end else if (rxUartStart) begin
                  rxState_reg <= spfm_pkg::SPFM_RX_START;
                  rxBits_reg <= (mode == `SPFM_MODE1) ? `SPFM_RXBITS_M1
                                : `SPFM_RXBITS_M23;
               end
            end
            spfm_pkg::SPFM_RX_START: begin
               // mid start bit: a glitch back to high aborts
               if (tick16 && rxTick_reg == `SPFM_OVS_MID) begin
                  rxTick_reg <= '0;
                  rxState_reg <= serialInPinIn ? spfm_pkg::SPFM_RX_IDLE
                                 : spfm_pkg::SPFM_RX_DATA;
               end else if (tick16) begin
                  rxTick_reg <= rxTick_reg + 1'b1;
               end
            end
            spfm_pkg::SPFM_RX_DATA: begin
               if (tick16) begin
                  rxTick_reg <= rxTick_reg + 1'b1;
               end
               if (tick16 && rxTick_reg == `SPFM_OVS_LAST) begin
                  rxShift_reg <= {serialInPinIn, rxShift_reg[9:1]};
                  rxBits_reg <= rxBits_reg - 1'b1;
                  if (rxBits_reg == 4'h1) begin
                     rxState_reg <= spfm_pkg::SPFM_RX_IDLE;
                  end
               end
            end
            spfm_pkg::SPFM_RX_SHIFT0: begin
               if (m0Step) begin
                  rxShift_reg <= {serialInPinIn, rxShift_reg[9:1]};
                  rxBits_reg <= rxBits_reg - 1'b1;
                  if (rxBits_reg == 4'h1) begin
                     rxState_reg <= spfm_pkg::SPFM_RX_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // align the finished frame: {ninth valid, ninth, data}
   always_comb begin
      rxWord = {2'h0, rxShift_reg[9:2]};
      rxAccept = 1'b1;
      if (rxState_reg == spfm_pkg::SPFM_RX_DATA) begin
         if (mode == `SPFM_MODE1) begin
            rxWord = {1'b1, serialInPinIn, rxShift_reg[9:2]};
            rxAccept = !ctrl_reg[`SPFM_CTL_MPE] || serialInPinIn;
         end else begin
            rxWord = {1'b1, rxShift_reg[9], rxShift_reg[8:1]};
            rxAccept = !ctrl_reg[`SPFM_CTL_MPE] || rxShift_reg[9];
         end
      end else begin
         rxWord = {2'h0, serialInPinIn, rxShift_reg[9:3]};
      end
   end

   // the buffer drains into the data register once the cpu clears ri
   assign rxPop = fifoOutValid && !rxDone_reg;

   spfm_pair_fifo #(
      .WIDTH(10),
      .DEPTH(RX_DEPTH)
   ) u_spfm_pair_fifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .inValid(rxFinish && rxAccept),
      .inReady(fifoInReady),
      .inData(rxWord),
      .outValid(fifoOutValid),
      .outReady(!rxDone_reg),
      .outData(fifoOutData)
   );

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rxData_reg <= `SPFM_RST_BYTE;
      end else if (rxPop) begin
         rxData_reg <= fifoOutData[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   logic [9:0] txLen_reg;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         txLen_reg <= '0;
      end else if (txStart) begin
         txLen_reg <= '0;
      end else if (txState_reg == spfm_pkg::SPFM_TX_SHIFT) begin
         txLen_reg <= txLen_reg + 1'b1;
      end
   end

   sequence m0ClockLow;
      !serialOutPin [*6];
   endsequence
   sequence m0ClockHigh;
      serialOutPin [*6];
   endsequence

   chk_tx_start_busy: assert property (
      txStart |=> txState_reg == spfm_pkg::SPFM_TX_SHIFT)
      else $error("data write did not start transmission");
   chk_m0_clock_rate: assert property (
      (mode == `SPFM_MODE0 && $fell(serialOutPin) && !txStart
       && !rxM0Start) |-> m0ClockLow ##1 serialOutPin)
      else $error("mode 0 shift clock low phase not six clocks");
   chk_m0_clock_high: assert property (
      (mode == `SPFM_MODE0 && $rose(serialOutPin)
       && txState_reg == spfm_pkg::SPFM_TX_SHIFT) |-> m0ClockHigh)
      else $error("mode 0 shift clock high phase not six clocks");
   chk_m2_frame_len: assert property (
      ($fell(txState_reg == spfm_pkg::SPFM_TX_SHIFT) && !$past(txStart)
       && mode == `SPFM_MODE2)
      |-> (smod ? (txLen_reg >= 10'd351 && txLen_reg <= 10'd352)
          : (txLen_reg >= 10'd701 && txLen_reg <= 10'd704)))
      else $error("mode 2 frame length not eleven bits at fixed rate");
   chk_ti_sticky: assert property (
      (txDone_reg && !wrCtrl) |=> txDone_reg)
      else $error("transmit done flag dropped without cpu clear");
   chk_ri_sticky: assert property (
      (rxDone_reg && !wrCtrl) |=> rxDone_reg)
      else $error("receive done flag dropped without cpu clear");
   chk_mpe_filter: assert property (
      (rxFinish && mode[1] && ctrl_reg[`SPFM_CTL_MPE] && !rxWord[8])
      |=> !$rose(fifoOutValid))
      else $error("multiprocessor frame with ninth bit 0 accepted");
   chk_ren_stops_rx: assert property (
      !ctrl_reg[`SPFM_CTL_REN] |=> rxState_reg == spfm_pkg::SPFM_RX_IDLE)
      else $error("receiver active with reception disabled");
   chk_irq_gate: assert property (
      (!ien_reg[`SPFM_IEN_EAL] || !ien_reg[`SPFM_IEN_ES]) |-> !serialIrq)
      else $error("serial request with an enable cleared");
   chk_irq_follow: assert property (
      ($rose(txDone_reg) && ien_reg[`SPFM_IEN_EAL]
       && ien_reg[`SPFM_IEN_ES]) |-> serialIrq)
      else $error("serial request missing after transmit done");
endmodule

/* verification/spfm_peer.sv */
// uart peer: drives the port's input line, captures its output line
// assumes 32 clk_sys cycles a bit and an idle-high line
`timescale 1ns/1ns
module spfm_peer (
   input wire logic clk_sys,
   input wire logic txLine,
   input wire logic dataLine,
   output logic rxLine
);
   initial rxLine = 1'b1;
   // start 0, lsb first, ninth (1 marks an address), stop 1
   task automatic send(input logic [7:0] d, input logic n9);
      logic [10:0] f;
      f = {1'b1, n9, d, 1'b0};
      @(posedge clk_sys);
      for (int i = 0; i < 11; i++) begin
         #1 rxLine = f[i];
         repeat (32) @(posedge clk_sys);
      end
   endtask
   // mode 0 shift-register peer: one data bit per rising shift clock
   task automatic grab0(output logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         @(posedge txLine);
         d[i] = dataLine;
      end
   endtask
   // bounded hunt for a start bit, then ten samples at mid-bit
   task automatic grab(output logic [9:0] f, output bit ok);
      ok = 1'b0;
      for (int i = 0; i < 400 && !ok; i++) begin
         @(posedge clk_sys);
         #1 ok = (txLine === 1'b0);
      end
      repeat (16) @(posedge clk_sys);
      for (int i = 0; i < 10; i++) begin
         repeat (32) @(posedge clk_sys);
         #1 f[i] = txLine;
      end
   endtask
endmodule

/* verification/tb_spfm_serial_port.sv */
// bench: sfr tasks drive the port, a uart peer judges the wire
// assumes 100 ns clock and 32 clocks a bit (smod 1, reload 3FF)
`timescale 1ns/1ns
`include "spfm_defines.svh"
module tb_spfm_serial_port;
   logic clk_sys, rst, sfrWrEn, sfrRdEn, peerLine, pinLevel;
   logic serialInPinOut, serialInPinOe, serialOutPin, serialIrq;
   logic [7:0] sfrAddr, sfrWrData, sfrRdData, rd, c;
   logic [9:0] fr;
   bit ok;
   int errTotal = 0;
   int nChecks = 0;
   // shared pin: the port drives it only in mode 0
   assign pinLevel = serialInPinOe ? serialInPinOut : peerLine;
   spfm_serial_port u_spfm_serial_port (.clk_sys(clk_sys), .rst(rst),
      .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn),
      .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
      .serialInPinIn(pinLevel), .serialInPinOut(serialInPinOut),
      .serialInPinOe(serialInPinOe), .serialOutPin(serialOutPin),
      .serialIrq(serialIrq));
   spfm_peer u_spfm_peer (.clk_sys(clk_sys), .txLine(serialOutPin),
      .dataLine(pinLevel), .rxLine(peerLine));
   ////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic check(input string what, input logic [9:0] seen, exp);
      nChecks++;
      if (seen !== exp) begin
         errTotal++;
         $display("mismatch %s exp %h seen %h", what, exp, seen);
      end
   endtask
   // one-cycle strobes, launched just after an edge
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk_sys);
      #1 sfrAddr = a;
      sfrWrData = d;
      sfrWrEn = 1'b1;
      @(posedge clk_sys);
      #1 sfrWrEn = 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge clk_sys);
      #1 sfrAddr = a;
      sfrRdEn = 1'b1;
      @(posedge clk_sys);
      #1 sfrRdEn = 1'b0;
      rd = sfrRdData;
   endtask
   ////////////////////////////////////////
   task automatic tTx();
      for (int m = 1; m < 4; m++) begin
         // mode 2 sends ninth 1, mode 3 sends 0
         c = {m[1:0], 2'b00, m == 2, 3'b000};
         wr(`SPFM_ADDR_CTRL, c);
         fork
            u_spfm_peer.grab(fr, ok);
            wr(`SPFM_ADDR_DATA, 8'h5A ^ 8'(m));
         join
         check("start", ok, 1'b1);
         check("data", fr[7:0], 8'h5A ^ 8'(m));
         check("bit8", fr[8], m != 3);
         if (m > 1)
            check("stop", fr[9], 1'b1);
         for (int i = 0; i < 100 && serialIrq !== 1'b1; i++)
            @(posedge clk_sys);
         check("ti irq", serialIrq, 1'b1);
         wr(`SPFM_ADDR_INTERRUPT_ENABLE_ZERO, 8'h10);
         check("gated", serialIrq, 1'b0);
         wr(`SPFM_ADDR_INTERRUPT_ENABLE_ZERO, 8'h90);
         wr(`SPFM_ADDR_CTRL, c);
         check("ti clr", serialIrq, 1'b0);
      end
      $display("transmit test done");
   endtask
   // mode 0: data out on the input pin, shift clock on the output pin
   task automatic tM0();
      wr(`SPFM_ADDR_CTRL, 8'h00);
      fork
         u_spfm_peer.grab0(rd);
         wr(`SPFM_ADDR_DATA, 8'hA6);
      join
      check("m0 data", rd, 8'hA6);
      for (int i = 0; i < 40 && serialIrq !== 1'b1; i++)
         @(posedge clk_sys);
      check("m0 ti", serialIrq, 1'b1);
      check("m0 oe", serialInPinOe, 1'b0);
      wr(`SPFM_ADDR_CTRL, 8'h00);
      $display("mode 0 test done");
   endtask
   // two address frames before the first read, one of them during a send
   task automatic tRx();
      wr(`SPFM_ADDR_CTRL, 8'hF0);
      u_spfm_peer.send(8'h11, 1'b0);
      check("data frame", serialIrq, 1'b0);
      u_spfm_peer.send(8'h3C, 1'b1);
      fork
         u_spfm_peer.send(8'hC3, 1'b1);
         u_spfm_peer.grab(fr, ok);
         wr(`SPFM_ADDR_DATA, 8'h96);
      join
      check("duplex tx", fr[7:0], 8'h96);
      repeat (40) @(posedge clk_sys);
      rdr(`SPFM_ADDR_CTRL);
      check("ri rb8", rd, 8'hF7);
      rdr(`SPFM_ADDR_DATA);
      check("first", rd, 8'h3C);
      wr(`SPFM_ADDR_CTRL, 8'hF0);
      rdr(`SPFM_ADDR_DATA);
      check("second", rd, 8'hC3);
      wr(`SPFM_ADDR_CTRL, 8'hE0);
      u_spfm_peer.send(8'h77, 1'b1);
      rdr(`SPFM_ADDR_CTRL);
      check("ren off", rd, 8'hE0);
      $display("receive test done");
   endtask
   task automatic closeOut();
      $display("checks %0d mismatches %0d", nChecks, errTotal);
      if (errTotal == 0 && nChecks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // watchdog: the whole run needs about 3800 cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      errTotal++;
      closeOut();
   end
   initial begin
      rst = 1'b1;
      sfrAddr = 8'h00;
      sfrWrData = 8'h00;
      sfrWrEn = 1'b0;
      sfrRdEn = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1 rst = 1'b0;
      rdr(`SPFM_ADDR_CTRL);
      check("ctrl rst", rd, 8'h00);
      rdr(8'h00);
      check("unmapped", rd, 8'h00);
      wr(`SPFM_ADDR_INTERRUPT_ENABLE_ZERO, 8'h90);
      wr(`SPFM_ADDR_PCON, 8'h80);
      wr(`SPFM_ADDR_RELL, 8'hFF);
      wr(`SPFM_ADDR_RELH, 8'h03);
      // reload counter counts up from zero once before it first reloads
      repeat (1100) @(posedge clk_sys);
      tTx();
      tM0();
      tRx();
      closeOut();
   end
endmodule
